// File: dra_defs.svh
`ifndef DRA_DEFS_SVH
`define DRA_DEFS_SVH

// ----------------------------------------
// Register map (addr[4]=global, addr[3]=channel, addr[2:0]=register)
// ----------------------------------------
`define DRA_ADDR_W 5
`define DRA_REG_CTRL 3'h0
`define DRA_REG_SRC 3'h1
`define DRA_REG_DST 3'h2
`define DRA_REG_RLD 3'h3
`define DRA_REG_CNT 3'h4
`define DRA_REG_FWD 3'h5
`define DRA_REG_AREA 3'h6
`define DRA_REG_SWTRIG 3'h0
`define DRA_REG_STATUS 3'h1

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DRA_CTRL_EN 0
`define DRA_CTRL_REQ 1
`define DRA_CTRL_KIND_LO 2
`define DRA_CTRL_KIND_HI 3
`define DRA_CTRL_SEL_LO 4
`define DRA_CTRL_SEL_HI 7
`define DRA_CTRL_RISE 8
`define DRA_CTRL_FWDDST 9
`define DRA_CTRL_UNIT16 10
`define DRA_CTRL_RESET 16'h0000

// Request source kinds
`define DRA_KIND_SW 2'h0
`define DRA_KIND_PERIPH 2'h1
`define DRA_KIND_EXT 2'h2

// ----------------------------------------
// Area codes and cycle weights
// ----------------------------------------
`define DRA_AREA_INT_NOWAIT 3'h0
`define DRA_AREA_INT_WAIT 3'h1
`define DRA_AREA_PERIPH 3'h2
`define DRA_AREA_SEP_NOWAIT 3'h3
`define DRA_AREA_SEP_WAIT 3'h4
`define DRA_AREA_MUX 3'h5
`define DRA_WEIGHT_1 4'h1
`define DRA_WEIGHT_2 4'h2
`define DRA_WEIGHT_3 4'h3
`define DRA_AREA_RLO 0
`define DRA_AREA_RHI 2
`define DRA_AREA_WLO 4
`define DRA_AREA_WHI 6

`define DRA_ONE_STEP 16'h0001
`define DRA_TWO_STEP 16'h0002

`endif

// File: dra_pkg.sv
package dra_pkg;
    typedef enum logic [1:0] {
        DRA_IDLE,
        DRA_XFER,
        DRA_CPU
    } dra_state_t;
endpackage

// File: dra_sync2.sv
`timescale 1ns/1ps
module dra_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// File: dra_cycle_weight.sv
`timescale 1ns/1ps
`include "dra_defs.svh"
module dra_cycle_weight (
    input wire logic [2:0] readArea,
    input wire logic [2:0] writeArea,
    input wire logic unit16,
    input wire logic byteBus,
    input wire logic readOdd,
    input wire logic writeOdd,
    output logic [3:0] totalCycles
);
    // ----------------------------------------
    // Weight of one bus cycle by target area
    // ----------------------------------------
    function automatic logic [3:0] areaWeight(input logic [2:0] area);
        if (area == `DRA_AREA_INT_NOWAIT || area == `DRA_AREA_SEP_NOWAIT) begin
            areaWeight = `DRA_WEIGHT_1;
        end else if (area == `DRA_AREA_MUX) begin
            areaWeight = `DRA_WEIGHT_3;
        end else begin
            areaWeight = `DRA_WEIGHT_2;
        end
    endfunction

    // 16-bit unit splits on an odd address or on a byte-wide bus, internal areas included
    wire logic readTwice = unit16 && (readOdd || byteBus); // RULE16
    wire logic writeTwice = unit16 && (writeOdd || byteBus); // RULE16
    wire logic [3:0] readW = areaWeight(readArea); // RULE1
    wire logic [3:0] writeW = areaWeight(writeArea); // RULE1
    wire logic [3:0] readPart = readTwice ? 4'((readW << 1)) : readW;
    wire logic [3:0] writePart = writeTwice ? 4'((writeW << 1)) : writeW;

    assign totalCycles = 4'(readPart + writePart); // RULE15
endmodule

// File: dra_top.sv
`timescale 1ns/1ps
`include "dra_defs.svh"
// Functional notes
// [RULE1] Bus cycle weight depends on target area
// [RULE2] First start after enable reloads forward pointer
// [RULE3] First start after enable reloads transfer counter
// [RULE4] Rewriting enable restarts channel from initial state
// [RULE5] Request flag sets regardless of enable
// [RULE6] Hardware clears flag just before transfer
// [RULE7] Software writes 0 clear flag, 1 ignored
// [RULE8] Software clears flag after changing source
// [RULE9] Source: peripheral request, software, external pin
// [RULE10] Peripheral source sets flag with its interrupt
// [RULE11] External pin edge per selection sets flag
// [RULE12] Simultaneous requests set all flags together
// [RULE13] Channel zero wins when both pending
// [RULE14] One CPU access between channel transfers
// [RULE15] Cycles equal reads times j plus writes times k
// [RULE16] Internal accesses use bus-width pin size
module dra_top #(
    parameter int N_PERIPH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`DRA_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic [N_PERIPH-1:0] periphIrq,
    input wire logic [1:0] extIntPin,
    input wire logic byteBus,
    output logic dmaOwnsBus,
    output logic cpuGrant,
    output logic activeChannel,
    output logic [3:0] xferCycles,
    output logic [15:0] xferAddr
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (N_PERIPH < 1 || N_PERIPH > 16) begin : g_bad_periph
        $error("N_PERIPH must lie between 1 and 16");
    end

    // ----------------------------------------
    // Reset release and pin synchronisation
    // ----------------------------------------
    logic rstMeta_n;
    logic rstSync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    logic [2:0] pinSync;
    logic [1:0] extPrev;
    dra_sync2 #(.WIDTH(3)) u_ext_sync (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .asyncIn({byteBus, extIntPin}),
        .syncOut(pinSync)
    );
    wire logic [1:0] extSync = pinSync[1:0];
    wire logic byteBusSync = pinSync[2];
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            extPrev <= 2'h0;
        end else begin
            extPrev <= extSync;
        end
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic isGlobal = regAddr[4];
    wire logic chanSel = regAddr[3];
    wire logic [2:0] regIdx = regAddr[2:0];
    wire logic swTrigWr = regWr && isGlobal && regIdx == `DRA_REG_SWTRIG;

    // ----------------------------------------
    // Per-channel state
    // ----------------------------------------
    dra_pkg::dra_state_t state;
    logic [15:0] ctrl [2];
    logic [15:0] srcPtr [2];
    logic [15:0] dstPtr [2];
    logic [15:0] rldCnt [2];
    logic [15:0] xferCnt [2];
    logic [15:0] fwdPtr [2];
    logic [6:0] area [2];
    logic [1:0] reloadPend;
    logic [1:0] setEv;
    logic [1:0] pend;
    logic [1:0] start;
    logic [1:0] finish;
    logic [15:0] effPtr [2];
    logic [15:0] reloadPtr [2];
    logic [3:0] cycLeft;
    logic [3:0] weight;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        wire logic selWr = regWr && !isGlobal && chanSel == 1'(i);
        wire logic ctrlWr = selWr && regIdx == `DRA_REG_CTRL;
        wire logic [1:0] kind = ctrl[i][`DRA_CTRL_KIND_HI:`DRA_CTRL_KIND_LO];
        wire logic [3:0] psel = ctrl[i][`DRA_CTRL_SEL_HI:`DRA_CTRL_SEL_LO];
        wire logic extRise = extSync[i] && !extPrev[i];
        wire logic extFall = !extSync[i] && extPrev[i];
        wire logic extEdge = ctrl[i][`DRA_CTRL_RISE] ? extRise : extFall; // RULE11
        wire logic periphHit = 32'(psel) < N_PERIPH && periphIrq[psel]; // RULE10
        wire logic swHit = swTrigWr && regWdata[i];
        wire logic flagClrSw = ctrlWr && !regWdata[`DRA_CTRL_REQ]; // RULE7
        wire logic [15:0] nextCtrlSw = {regWdata[15:2], ctrl[i][`DRA_CTRL_REQ],
            regWdata[`DRA_CTRL_EN]};

        // Source selection feeds one request line per channel
        assign setEv[i] = (kind == `DRA_KIND_SW && swHit) // RULE9
            || (kind == `DRA_KIND_PERIPH && periphHit) // RULE10
            || (kind == `DRA_KIND_EXT && extEdge); // RULE11
        assign pend[i] = ctrl[i][`DRA_CTRL_EN] && ctrl[i][`DRA_CTRL_REQ];
        assign reloadPtr[i] = ctrl[i][`DRA_CTRL_FWDDST] ? dstPtr[i] : srcPtr[i];
        assign effPtr[i] = reloadPend[i] ? reloadPtr[i] : fwdPtr[i];

        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                ctrl[i] <= `DRA_CTRL_RESET;
            end else begin
                if (ctrlWr) begin
                    ctrl[i] <= nextCtrlSw;
                end
                if (finish[i] && xferCnt[i] == `DRA_ONE_STEP && !ctrlWr) begin
                    ctrl[i][`DRA_CTRL_EN] <= 1'b0;
                end
                // Set wins over both hardware and software clear
                if (setEv[i]) begin
                    ctrl[i][`DRA_CTRL_REQ] <= 1'b1; // RULE5 RULE12
                end else if (start[i] || flagClrSw) begin
                    ctrl[i][`DRA_CTRL_REQ] <= 1'b0; // RULE6 RULE7
                end
            end
        end

        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                reloadPend[i] <= 1'b0;
            end else if (ctrlWr && regWdata[`DRA_CTRL_EN]) begin
                reloadPend[i] <= 1'b1; // RULE4
            end else if (start[i]) begin
                reloadPend[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                srcPtr[i] <= 16'h0000;
                dstPtr[i] <= 16'h0000;
                rldCnt[i] <= 16'h0000;
                area[i] <= 7'h00;
            end else if (selWr) begin
                if (regIdx == `DRA_REG_SRC) begin
                    srcPtr[i] <= regWdata;
                end else if (regIdx == `DRA_REG_DST) begin
                    dstPtr[i] <= regWdata;
                end else if (regIdx == `DRA_REG_RLD) begin
                    rldCnt[i] <= regWdata;
                end else if (regIdx == `DRA_REG_AREA) begin
                    area[i] <= regWdata[6:0];
                end
            end
        end

        always_ff @(posedge clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                fwdPtr[i] <= 16'h0000;
                xferCnt[i] <= 16'h0000;
            end else if (start[i] && reloadPend[i]) begin
                fwdPtr[i] <= reloadPtr[i]; // RULE2
                xferCnt[i] <= rldCnt[i]; // RULE3
            end else if (finish[i]) begin
                fwdPtr[i] <= ctrl[i][`DRA_CTRL_UNIT16] ? 16'(fwdPtr[i] + `DRA_TWO_STEP)
                    : 16'(fwdPtr[i] + `DRA_ONE_STEP);
                xferCnt[i] <= 16'(xferCnt[i] - `DRA_ONE_STEP);
            end
        end
    end

    // ----------------------------------------
    // Arbitration and bus ownership
    // ----------------------------------------
    wire logic grantZero = state == dra_pkg::DRA_IDLE && pend[0]; // RULE13
    wire logic grantOne = state == dra_pkg::DRA_IDLE && !pend[0] && pend[1];
    wire logic nextChan = grantOne;
    wire logic xferEnd = state == dra_pkg::DRA_XFER && cycLeft == 4'h1;
    wire logic [15:0] selPtr = effPtr[nextChan];
    wire logic selFwdDst = ctrl[nextChan][`DRA_CTRL_FWDDST];
    wire logic [15:0] selRdAddr = selFwdDst ? srcPtr[nextChan] : selPtr;
    wire logic [15:0] selWrAddr = selFwdDst ? selPtr : dstPtr[nextChan];

    assign start = {grantOne, grantZero};
    assign finish = {xferEnd && activeChannel, xferEnd && !activeChannel};

    dra_cycle_weight u_weight (
        .readArea(area[nextChan][`DRA_AREA_RHI:`DRA_AREA_RLO]),
        .writeArea(area[nextChan][`DRA_AREA_WHI:`DRA_AREA_WLO]),
        .unit16(ctrl[nextChan][`DRA_CTRL_UNIT16]),
        .byteBus(byteBusSync),
        .readOdd(selRdAddr[0]),
        .writeOdd(selWrAddr[0]),
        .totalCycles(weight)
    );

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= dra_pkg::DRA_IDLE;
            cycLeft <= 4'h0;
            activeChannel <= 1'b0;
            xferCycles <= 4'h0;
            xferAddr <= 16'h0000;
        end else begin
            case (state)
                dra_pkg::DRA_IDLE: begin
                    if (grantZero || grantOne) begin
                        state <= dra_pkg::DRA_XFER;
                        activeChannel <= nextChan;
                        cycLeft <= weight; // RULE1 RULE15
                        xferCycles <= weight;
                        xferAddr <= selPtr;
                    end
                end
                dra_pkg::DRA_XFER: begin
                    cycLeft <= 4'(cycLeft - 4'h1);
                    if (xferEnd) begin
                        state <= dra_pkg::DRA_CPU; // RULE14
                    end
                end
                dra_pkg::DRA_CPU: begin
                    state <= dra_pkg::DRA_IDLE;
                end
                default: begin
                    state <= dra_pkg::DRA_IDLE;
                end
            endcase
        end
    end

    assign dmaOwnsBus = state == dra_pkg::DRA_XFER;
    assign cpuGrant = state != dra_pkg::DRA_XFER;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire logic [15:0] statusWord = {9'h000, reloadPend, activeChannel, dmaOwnsBus,
        state == dra_pkg::DRA_CPU, pend};
    wire logic [15:0] chanWord = regIdx == `DRA_REG_CTRL ? ctrl[chanSel]
        : regIdx == `DRA_REG_SRC ? srcPtr[chanSel]
        : regIdx == `DRA_REG_DST ? dstPtr[chanSel]
        : regIdx == `DRA_REG_RLD ? rldCnt[chanSel]
        : regIdx == `DRA_REG_CNT ? xferCnt[chanSel]
        : regIdx == `DRA_REG_FWD ? fwdPtr[chanSel]
        : regIdx == `DRA_REG_AREA ? {9'h000, area[chanSel]} : 16'h0000;
    wire logic [15:0] readWord = !isGlobal ? chanWord
        : regIdx == `DRA_REG_STATUS ? statusWord : 16'h0000;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            regRdata <= readWord;
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_flag_set;
        @(posedge clk) disable iff (!rstSync_n)
        setEv[0] |=> ctrl[0][`DRA_CTRL_REQ];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Request flag not set"); // RULE5

    property p_flag_clear;
        @(posedge clk) disable iff (!rstSync_n)
        (start[1] && !setEv[1]) |=> !ctrl[1][`DRA_CTRL_REQ] && dmaOwnsBus;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Flag kept at start"); // RULE6

    property p_sw_one;
        @(posedge clk) disable iff (!rstSync_n)
        (regWr && !isGlobal && chanSel && regIdx == `DRA_REG_CTRL
            && regWdata[`DRA_CTRL_REQ] && !ctrl[1][`DRA_CTRL_REQ] && !setEv[1])
            |=> !ctrl[1][`DRA_CTRL_REQ];
    endproperty
    a_sw_one: assert property (p_sw_one) else $error("Software set the flag"); // RULE7

    property p_both;
        @(posedge clk) disable iff (!rstSync_n)
        (setEv[0] && setEv[1]) |=> ctrl[0][`DRA_CTRL_REQ] && ctrl[1][`DRA_CTRL_REQ];
    endproperty
    a_both: assert property (p_both) else $error("Flags not set together"); // RULE12

    property p_prio;
        @(posedge clk) disable iff (!rstSync_n)
        (state == dra_pkg::DRA_IDLE && pend == 2'h3) |=> dmaOwnsBus && !activeChannel;
    endproperty
    a_prio: assert property (p_prio) else $error("Channel one beat channel zero"); // RULE13

    property p_cpu_slot;
        @(posedge clk) disable iff (!rstSync_n)
        xferEnd |=> cpuGrant ##1 !dmaOwnsBus;
    endproperty
    a_cpu_slot: assert property (p_cpu_slot) else $error("CPU slot skipped"); // RULE14

    property p_reload;
        @(posedge clk) disable iff (!rstSync_n)
        (start[0] && reloadPend[0]) |=> fwdPtr[0] == $past(reloadPtr[0])
            && xferCnt[0] == $past(rldCnt[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("Reload missing at start"); // RULE2 RULE3

    property p_restart;
        @(posedge clk) disable iff (!rstSync_n)
        (regWr && !isGlobal && chanSel && regIdx == `DRA_REG_CTRL && regWdata[`DRA_CTRL_EN])
            |=> reloadPend[1];
    endproperty
    a_restart: assert property (p_restart) else $error("Enable rewrite not restarting"); // RULE4

    property p_length;
        @(posedge clk) disable iff (!rstSync_n)
        (state == dra_pkg::DRA_IDLE && pend != 2'h0 && weight == 4'h2)
            |=> dmaOwnsBus [*2] ##1 !dmaOwnsBus;
    endproperty
    a_length: assert property (p_length) else $error("Transfer length wrong"); // RULE1 RULE15
endmodule

// File: dra_far_model.sv
`timescale 1ns/1ps
module dra_far_model (
    input wire logic clk,
    input wire logic fireIrq,
    input wire logic [3:0] irqIdx,
    input wire logic [1:0] pinLevel,
    output logic [15:0] periphIrq,
    output logic [1:0] extIntPin
);
    // ----------------------------------------
    // Peripheral event: one-cycle request pulse
    // ----------------------------------------
    always @(posedge clk) begin
        periphIrq <= fireIrq ? (16'h0001 << irqIdx) : 16'h0000;
    end

    // ----------------------------------------
    // External pins: skewed against the clock
    // ----------------------------------------
    initial begin
        extIntPin = 2'h0;
        forever begin
            @(pinLevel);
            #3 extIntPin = pinLevel;
        end
    end
endmodule

// File: dma_request_enable_arbiter_test.sv
`timescale 1ns/1ps
`include "dra_defs.svh"
module dma_request_enable_arbiter_test;
    logic clk, rst_n, regWr, regRd, byteBus, dmaOwnsBus, cpuGrant, activeChannel, fireIrq;
    logic [`DRA_ADDR_W-1:0] regAddr;
    logic [15:0] regWdata, regRdata, xferAddr, periphIrq, rd;
    logic [3:0] irqIdx, xferCycles;
    logic [1:0] pinLevel, extIntPin;
    logic [3:0] w [6] = '{`DRA_WEIGHT_1, `DRA_WEIGHT_2, `DRA_WEIGHT_2,
                          `DRA_WEIGHT_1, `DRA_WEIGHT_2, `DRA_WEIGHT_3};
    int fail_count = 0, checked = 0, cycles = 0, gap;

    dra_top dra_top_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .periphIrq(periphIrq),
        .extIntPin(extIntPin), .byteBus(byteBus), .dmaOwnsBus(dmaOwnsBus),
        .cpuGrant(cpuGrant), .activeChannel(activeChannel), .xferCycles(xferCycles),
        .xferAddr(xferAddr));
    dra_far_model dra_far_model_i (.clk(clk), .fireIrq(fireIrq), .irqIdx(irqIdx),
        .pinLevel(pinLevel), .periphIrq(periphIrq), .extIntPin(extIntPin));

    // ----------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [4:0] ra(input logic ch, input logic [2:0] r);
        return {1'b0, ch, r};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rdr(input logic [4:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        rd = regRdata;
    endtask
    task automatic sw(input logic [15:0] m);
        wr({2'b10, `DRA_REG_SWTRIG}, m);
    endtask
    task automatic xfer(input logic ch, input logic [15:0] a, input logic [3:0] cyc,
                        input int expGap);
        int n;
        n = 0;
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (dmaOwnsBus !== 1'b1 && gap < 60);
        chk("owns", 16'h0001, {15'h0, dmaOwnsBus});
        chk("chan", {15'h0, ch}, {15'h0, activeChannel});
        chk("addr", a, xferAddr);
        chk("weight", {12'h0, cyc}, {12'h0, xferCycles});
        while (dmaOwnsBus === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("length", {12'h0, cyc}, n[15:0]);
        chk("slot", 16'h0001, {15'h0, cpuGrant});
        if (expGap >= 0) chk("gap", expGap[15:0], gap[15:0]);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("own0", 16'h0000, {15'h0, dmaOwnsBus});
        chk("grant0", 16'h0001, {15'h0, cpuGrant});
        rdr(5'h07);
        chk("unmapped", 16'h0000, rd);
    endtask
    task automatic t_flag();
        wr(ra(1, `DRA_REG_CTRL), 16'h0000);
        sw(16'h0002);
        rdr(ra(1, `DRA_REG_CTRL));
        chk("flagSet", 16'h0001, {15'h0, rd[`DRA_CTRL_REQ]});
        wr(ra(1, `DRA_REG_CTRL), 16'h0002);
        rdr(ra(1, `DRA_REG_CTRL));
        chk("flagKept", 16'h0001, {15'h0, rd[`DRA_CTRL_REQ]});
        wr(ra(1, `DRA_REG_CTRL), 16'h0000);
        wr(ra(1, `DRA_REG_CTRL), 16'h0002);
        rdr(ra(1, `DRA_REG_CTRL));
        chk("flagClr", 16'h0000, {15'h0, rd[`DRA_CTRL_REQ]});
        chk("idleOwn", 16'h0000, {15'h0, dmaOwnsBus});
    endtask
    task automatic t_reload();
        wr(ra(0, `DRA_REG_SRC), 16'h1234);
        wr(ra(0, `DRA_REG_DST), 16'h5678);
        wr(ra(0, `DRA_REG_RLD), 16'h0003);
        wr(ra(0, `DRA_REG_AREA), 16'h0025);
        wr(ra(0, `DRA_REG_CTRL), 16'h0001);
        sw(16'h0001);
        xfer(0, 16'h1234, 4'h5, -1);
        rdr(ra(0, `DRA_REG_CNT));
        chk("count", 16'h0002, rd);
        rdr(ra(0, `DRA_REG_CTRL));
        chk("flagHw", 16'h0000, {15'h0, rd[`DRA_CTRL_REQ]});
        sw(16'h0001);
        xfer(0, 16'h1235, 4'h5, -1);
        wr(ra(0, `DRA_REG_CTRL), 16'h0201);
        sw(16'h0001);
        xfer(0, 16'h5678, 4'h5, -1);
        rdr(ra(0, `DRA_REG_CNT));
        chk("recount", 16'h0002, rd);
    endtask
    task automatic t_weights();
        logic [2:0] c;
        wr(ra(0, `DRA_REG_RLD), 16'h0010);
        wr(ra(0, `DRA_REG_CTRL), 16'h0001);
        for (int a = 0; a < 6; a++) begin
            c = a[2:0];
            wr(ra(0, `DRA_REG_AREA), {9'h0, c, 1'b0, c});
            sw(16'h0001);
            xfer(0, 16'h1234 + a[15:0], w[a] + w[a], -1);
        end
    endtask
    task automatic t_width();
        wr(ra(0, `DRA_REG_AREA), 16'h0000);
        wr(ra(0, `DRA_REG_CTRL), 16'h0401);
        byteBus <= 1'b1;
        sw(16'h0001);
        xfer(0, 16'h1234, 4'h4, -1);
        @(posedge clk);
        byteBus <= 1'b0;
        sw(16'h0001);
        xfer(0, 16'h1236, 4'h2, -1);
        wr(ra(0, `DRA_REG_SRC), 16'h1235);
        wr(ra(0, `DRA_REG_CTRL), 16'h0401);
        sw(16'h0001);
        xfer(0, 16'h1235, 4'h3, -1);
    endtask
    task automatic t_periph();
        wr(ra(1, `DRA_REG_SRC), 16'h0100);
        wr(ra(1, `DRA_REG_RLD), 16'h0004);
        wr(ra(1, `DRA_REG_AREA), 16'h0000);
        wr(ra(1, `DRA_REG_CTRL), 16'h0034);
        wr(ra(1, `DRA_REG_CTRL), 16'h0035);
        @(posedge clk);
        irqIdx <= 4'h4;
        fireIrq <= 1'b1;
        @(posedge clk);
        fireIrq <= 1'b0;
        repeat (10) @(negedge clk);
        chk("otherIrq", 16'h0000, {15'h0, dmaOwnsBus});
        @(posedge clk);
        irqIdx <= 4'h3;
        fireIrq <= 1'b1;
        @(posedge clk);
        fireIrq <= 1'b0;
        xfer(1, 16'h0100, 4'h2, -1);
    endtask
    task automatic t_dual();
        wr(ra(1, `DRA_REG_AREA), 16'h0011);
        wr(ra(0, `DRA_REG_CTRL), 16'h0108);
        wr(ra(0, `DRA_REG_CTRL), 16'h0109);
        wr(ra(1, `DRA_REG_CTRL), 16'h0108);
        wr(ra(1, `DRA_REG_CTRL), 16'h0109);
        @(posedge clk);
        pinLevel <= 2'h3;
        xfer(0, 16'h1235, 4'h2, -1);
        xfer(1, 16'h0100, 4'h4, 2);
        @(posedge clk);
        pinLevel <= 2'h0;
        repeat (12) @(negedge clk);
        chk("fallEdge", 16'h0000, {15'h0, dmaOwnsBus});
        wr(ra(1, `DRA_REG_CTRL), 16'h0008);
        wr(ra(1, `DRA_REG_CTRL), 16'h0009);
        @(posedge clk);
        pinLevel <= 2'h2;
        repeat (12) @(negedge clk);
        chk("riseIgnored", 16'h0000, {15'h0, dmaOwnsBus});
        @(posedge clk);
        pinLevel <= 2'h0;
        xfer(1, 16'h0100, 4'h4, -1);
    endtask

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = '0;
        regWdata = 16'h0000;
        byteBus = 1'b0;
        fireIrq = 1'b0;
        irqIdx = 4'h0;
        pinLevel = 2'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_flag();
        t_reload();
        t_weights();
        t_width();
        t_periph();
        t_dual();
        print_verdict();
    end
endmodule
